// ===== design/dlp_defs.svh
`ifndef DLP_DEFS_SVH
`define DLP_DEFS_SVH
// Clock period of clk_sys in ns
`define DLP_CLK_NS       10
// Memory timing figures in ns
`define DLP_T_REFI_NS    7800
`define DLP_T_CKE_NS     8
`define DLP_T_XP_NS      24
`define DLP_T_RFC_NS     160
`define DLP_T_CKESR_NS   10
`define DLP_T_XS_NS      170
// Least times round up, the refresh interval rounds down
`define DLP_CEIL(t)      (((t) + `DLP_CLK_NS - 1) / `DLP_CLK_NS)
`define DLP_REFI_CYC     (`DLP_T_REFI_NS / `DLP_CLK_NS)
`define DLP_CKE_CYC      `DLP_CEIL(`DLP_T_CKE_NS)
`define DLP_XP_CYC       `DLP_CEIL(`DLP_T_XP_NS)
`define DLP_RFC_CYC      `DLP_CEIL(`DLP_T_RFC_NS)
`define DLP_CKESR_CYC    `DLP_CEIL(`DLP_T_CKESR_NS)
`define DLP_XS_CYC       `DLP_CEIL(`DLP_T_XS_NS)
// Commands as {cs_n, ras_n, cas_n, we_n}
`define DLP_CMD_NOP      4'h7
`define DLP_CMD_REF      4'h1
// Error-correction register offsets and reset values
`define DLP_ECC_STAT     4'h0
`define DLP_ECC_MASK     4'h1
`define DLP_ECC_CNT_SGL  4'h2
`define DLP_ECC_CNT_DBL  4'h3
`define DLP_ECC_MASK_RST 2'h0
`endif

// ===== design/dlp_pkg.sv
package dlp_pkg;
    // Power sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_PD, ST_PD_EXIT, ST_REF, ST_SR, ST_SR_EXIT
    } dlp_state_t;
    typedef logic [3:0] dlp_cmd_t;
endpackage : dlp_pkg

// ===== design/dlp_buf.sv
`timescale 1ns/100ps
`include "dlp_defs.svh"
module dlp_buf #(
    parameter int W     = 18,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    // Filling side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // Draining side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    import dlp_pkg::*;
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           rd;
        logic [AW-1:0]           wr;
        logic [AW:0]             cnt;
    } dlp_buf_s_t;
    dlp_buf_s_t q;
    dlp_buf_s_t d;
    logic       push;
    logic       pop;

    // Honest flags straight from the occupancy count
    assign in_ready  = (q.cnt != (AW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data  = q.mem[q.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer update wraps at DEPTH, so non-power-of-two depths work
    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wr] = in_data;
            d.wr = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
        end
        if (pop) begin
            d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
        end
        d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule : dlp_buf

// ===== design/dlp_eccreg.sv
`timescale 1ns/100ps
`include "dlp_defs.svh"
module dlp_eccreg #(
    parameter int AW = 4
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    // Register port
    input  wire logic [AW-1:0] ecc_addr,
    input  wire logic [3:0]    eccport_byte_enable,
    input  wire logic [31:0]   ecc_wdata,
    input  wire logic          ecc_read_req,
    input  wire logic          ecc_write_req,
    output logic [31:0]        ecc_rdata,
    // Error events and interrupt
    input  wire logic          ecc_err_single,
    input  wire logic          ecc_err_double,
    output logic               ecc_interrupt
);
    import dlp_pkg::*;
    typedef struct packed {
        logic [1:0]  stat;
        logic [1:0]  mask;
        logic [15:0] cnt_s;
        logic [15:0] cnt_d;
        logic [31:0] rdata;
        logic        irq;
    } dlp_ecc_s_t;
    localparam dlp_ecc_s_t RST = '{mask: `DLP_ECC_MASK_RST, default: '0};
    dlp_ecc_s_t q;
    dlp_ecc_s_t d;
    logic       wr_hit;
    logic [1:0] w1c;

    // Byte lane 0 gates all fields; the only data bits written sit in the low byte
    function automatic logic lane0(input logic wr, input logic [3:0] be);
        return wr && be[0];
    endfunction : lane0

    assign wr_hit = lane0(ecc_write_req, eccport_byte_enable);
    assign w1c    = (wr_hit && ecc_addr == AW'(`DLP_ECC_STAT)) ? ecc_wdata[1:0] : 2'h0;

    always_comb begin
        d = q;
        // Set beats the write-one clear in the same cycle
        d.stat = (q.stat & ~w1c) | {ecc_err_double, ecc_err_single};
        if (wr_hit && ecc_addr == AW'(`DLP_ECC_MASK)) begin
            d.mask = ecc_wdata[1:0];
        end
        // Counters saturate; a write clears them
        if (wr_hit && ecc_addr == AW'(`DLP_ECC_CNT_SGL)) begin
            d.cnt_s = '0;
        end else if (ecc_err_single && q.cnt_s != 16'hffff) begin
            d.cnt_s = q.cnt_s + 16'h1;
        end
        if (wr_hit && ecc_addr == AW'(`DLP_ECC_CNT_DBL)) begin
            d.cnt_d = '0;
        end else if (ecc_err_double && q.cnt_d != 16'hffff) begin
            d.cnt_d = q.cnt_d + 16'h1;
        end
        // Read answer lands one cycle after the request; unmapped reads zero
        if (ecc_read_req) begin
            unique case (ecc_addr)
                AW'(`DLP_ECC_STAT):    d.rdata = {30'h0, q.stat};
                AW'(`DLP_ECC_MASK):    d.rdata = {30'h0, q.mask};
                AW'(`DLP_ECC_CNT_SGL): d.rdata = {16'h0, q.cnt_s};
                AW'(`DLP_ECC_CNT_DBL): d.rdata = {16'h0, q.cnt_d};
                default:               d.rdata = 32'h0;
            endcase
        end
        d.irq = |(d.stat & ~d.mask);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign ecc_rdata     = q.rdata;
    assign ecc_interrupt = q.irq;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    chk_irq_on_error: assert property (ecc_err_single && !q.mask[0] && !ecc_write_req |=> ecc_interrupt)
        else $error("Unmasked single error raised no interrupt");
    chk_read_answer: assert property (ecc_read_req && ecc_addr == AW'(`DLP_ECC_MASK)
        |=> ecc_rdata == {30'h0, $past(q.mask)})
        else $error("Mask read returned wrong data");
endmodule : dlp_eccreg

// ===== design/dlp_ctrl.sv
// Summary of operation
// - Enter power-down when legal, then acknowledge
// - Stay in power-down while request held
// - Leave power-down periodically for auto-refresh
// - Drop power-down ack only after exit
// - Power-down handshake only when option enabled
// - Enter self-refresh when legal, then acknowledge
// - Stay in self-refresh while request held
// - Drop self-refresh ack only after exit
// - Self-refresh handshake only when option enabled
// - Memory data bus half the local width
// - Strobes go with writes, capture reads
// - Byte mask hides disabled write bytes
// - Register port: address, enables, data, requests
// - Error conditions raise a dedicated interrupt
// - All local signals on the system clock
// - Refresh ack pulses once per refresh
`timescale 1ns/100ps
`include "dlp_defs.svh"
module dlp_ctrl #(
    parameter bit PD_EN    = 1'b1,
    parameter bit SR_EN    = 1'b1,
    parameter int DQ_W     = 8,
    parameter int DQS_HALF = 4,
    parameter int ECC_AW   = 4
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 reset_n,
    // Power control handshake
    input  wire logic                 pwrdn_req,
    output logic                      pwrdn_ack,
    input  wire logic                 selfref_req,
    output logic                      selfref_ack,
    output logic                      refresh_ack,
    // Write stream
    input  wire logic [2*DQ_W-1:0]    wr_data,
    input  wire logic [2*DQ_W/8-1:0]  wr_be,
    input  wire logic                 wr_valid,
    output logic                      wr_ready,
    // Read stream
    output logic [2*DQ_W-1:0]         rd_data,
    output logic                      rd_valid,
    // Memory command pins
    output logic                      dram_cke,
    output logic                      dram_cs_n,
    output logic                      dram_ras_n,
    output logic                      dram_cas_n,
    output logic                      dram_we_n,
    // Memory data pins
    input  wire logic [DQ_W-1:0]      dram_dq_i,
    output logic [DQ_W-1:0]           dram_dq_o,
    output logic                      dram_dq_oe,
    input  wire logic [DQ_W/8-1:0]    dram_dqs_i,
    output logic [DQ_W/8-1:0]         dram_dqs_o,
    output logic                      dram_dqs_oe,
    input  wire logic [DQ_W/8-1:0]    dram_dqs_n_i,
    output logic [DQ_W/8-1:0]         dram_dqs_n_o,
    output logic                      dram_dqs_n_oe,
    output logic [DQ_W/8-1:0]         dram_byte_mask,
    // Error-correction register port
    input  wire logic [ECC_AW-1:0]    ecc_addr,
    input  wire logic [3:0]           eccport_byte_enable,
    input  wire logic [31:0]          ecc_wdata,
    input  wire logic                 ecc_read_req,
    input  wire logic                 ecc_write_req,
    output logic [31:0]               ecc_rdata,
    input  wire logic                 ecc_err_single,
    input  wire logic                 ecc_err_double,
    output logic                      ecc_interrupt
);
    import dlp_pkg::*;
    localparam int NB = DQ_W / 8;
    localparam int BW = 2 * DQ_W + 2 * NB;

    typedef struct packed {
        dlp_state_t        st;
        logic [9:0]        wait_cnt;
        logic [9:0]        ref_cnt;
        logic              ref_due;
        logic              pd_ack;
        logic              sr_ack;
        logic              ref_ack;
        logic              cke;
        dlp_cmd_t          cmd;
        logic [2:0]        dqs_sync;
        logic [DQ_W-1:0]   dq_s1;
        logic [DQ_W-1:0]   dq_s2;
        logic              rd_beat;
        logic [DQ_W-1:0]   rd_lo;
        logic [2*DQ_W-1:0] rd_data;
        logic              rd_valid;
        logic              wr_act;
        logic              wr_beat;
        logic [3:0]        wr_ph;
        logic [2*DQ_W-1:0] wr_word;
        logic [2*NB-1:0]   wr_be;
        logic [DQ_W-1:0]   dq_o;
        logic [NB-1:0]     dm;
        logic              dqs_o;
        logic              oe;
    } dlp_ctrl_s_t;

    localparam dlp_ctrl_s_t RST = '{
        st:      ST_IDLE,
        ref_cnt: 10'(`DLP_REFI_CYC),
        cke:     1'b1,
        cmd:     `DLP_CMD_NOP,
        default: '0
    };

    dlp_ctrl_s_t     q;
    dlp_ctrl_s_t     d;
    logic            pd_go;
    logic            sr_go;
    logic            drain_ok;
    logic            buf_valid;
    logic [BW-1:0]   buf_data;
    logic            buf_take;

    // Disabled options leave the handshake inert: the request is ignored
    assign pd_go = PD_EN && pwrdn_req;
    assign sr_go = SR_EN && selfref_req;

    // Words are drained only when no power or refresh work is waiting,
    // so a low-power entry never cuts a burst in half
    assign drain_ok = (q.st == ST_IDLE) && !q.wr_act && !q.ref_due && !pd_go && !sr_go;
    assign buf_take = buf_valid && drain_ok;

    // Two-entry buffer absorbs the stall while the memory sleeps
    dlp_buf #(
        .W     (BW),
        .DEPTH (2)
    ) u_wbuf (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .in_data   ({wr_be, wr_data}),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_take)
    );

    // Next-state logic for the whole block
    always_comb begin
        d = q;
        d.cmd      = `DLP_CMD_NOP;
        d.ref_ack  = 1'b0;
        d.rd_valid = 1'b0;
        // Strobe and data pins pass two flops before use
        d.dqs_sync = {q.dqs_sync[1:0], dram_dqs_i[0]};
        d.dq_s1    = dram_dq_i;
        d.dq_s2    = q.dq_s1;
        if (q.wait_cnt != '0) begin
            d.wait_cnt = q.wait_cnt - 10'h1;
        end

        // Refresh interval timer; the memory refreshes itself in self-refresh
        if (q.st == ST_SR || q.st == ST_SR_EXIT) begin
            d.ref_cnt = 10'(`DLP_REFI_CYC);
        end else if (q.ref_cnt == '0) begin
            d.ref_cnt = 10'(`DLP_REFI_CYC);
        end else begin
            d.ref_cnt = q.ref_cnt - 10'h1;
        end

        unique case (q.st)
            ST_IDLE: begin
                if (q.ref_due && !q.wr_act) begin
                    d.cmd      = `DLP_CMD_REF;
                    d.ref_ack  = 1'b1;
                    d.wait_cnt = 10'(`DLP_RFC_CYC);
                    d.st       = ST_REF;
                end else if (sr_go && !q.wr_act) begin
                    // Entry as soon as the data path is quiet
                    d.cmd      = `DLP_CMD_REF;
                    d.cke      = 1'b0;
                    d.sr_ack   = 1'b1;
                    d.wait_cnt = 10'(`DLP_CKESR_CYC);
                    d.st       = ST_SR;
                end else if (pd_go && !q.wr_act) begin
                    d.cke      = 1'b0;
                    d.pd_ack   = 1'b1;
                    d.wait_cnt = 10'(`DLP_CKE_CYC);
                    d.st       = ST_PD;
                end
            end
            ST_PD: begin
                // Held low until the user lets go or a refresh falls due
                if (q.wait_cnt == '0 && (!pwrdn_req || q.ref_due)) begin
                    d.cke      = 1'b1;
                    d.wait_cnt = 10'(`DLP_XP_CYC);
                    d.st       = ST_PD_EXIT;
                end
            end
            ST_PD_EXIT: begin
                if (q.wait_cnt == '0) begin
                    if (q.ref_due) begin
                        d.cmd      = `DLP_CMD_REF;
                        d.ref_ack  = 1'b1;
                        d.wait_cnt = 10'(`DLP_RFC_CYC);
                        d.st       = ST_REF;
                    end else begin
                        // Exit finished, only now may the ack fall
                        d.pd_ack = 1'b0;
                        d.st     = ST_IDLE;
                    end
                end
            end
            ST_REF: begin
                if (q.wait_cnt == '0) begin
                    if (q.pd_ack && pd_go) begin
                        // Back to sleep after a refresh excursion
                        d.cke      = 1'b0;
                        d.wait_cnt = 10'(`DLP_CKE_CYC);
                        d.st       = ST_PD;
                    end else begin
                        d.pd_ack = 1'b0;
                        d.st     = ST_IDLE;
                    end
                end
            end
            ST_SR: begin
                if (q.wait_cnt == '0 && !selfref_req) begin
                    d.cke      = 1'b1;
                    d.wait_cnt = 10'(`DLP_XS_CYC);
                    d.st       = ST_SR_EXIT;
                end
            end
            ST_SR_EXIT: begin
                if (q.wait_cnt == '0) begin
                    d.sr_ack = 1'b0;
                    d.st     = ST_IDLE;
                end
            end
        endcase

        // A due flag raised by the timer wins over the clear of an issue
        d.ref_due = (q.ref_cnt == '0 && q.st != ST_SR && q.st != ST_SR_EXIT)
                  || (q.ref_due && !d.ref_ack);

        // Write serializer: low half with strobe high, then high half
        if (buf_take) begin
            d.wr_act  = 1'b1;
            d.wr_beat = 1'b0;
            d.wr_ph   = 4'(DQS_HALF - 1);
            d.wr_word = buf_data[2*DQ_W-1:0];
            d.wr_be   = buf_data[BW-1:2*DQ_W];
            d.dq_o    = buf_data[DQ_W-1:0];
            d.dm      = ~buf_data[2*DQ_W+NB-1:2*DQ_W];
            d.dqs_o   = 1'b1;
            d.oe      = 1'b1;
        end else if (q.wr_act) begin
            if (q.wr_ph != '0) begin
                d.wr_ph = q.wr_ph - 4'h1;
            end else if (!q.wr_beat) begin
                d.wr_beat = 1'b1;
                d.wr_ph   = 4'(DQS_HALF - 1);
                d.dq_o    = q.wr_word[2*DQ_W-1:DQ_W];
                d.dm      = ~q.wr_be[2*NB-1:NB];
                d.dqs_o   = 1'b0;
            end else begin
                d.wr_act = 1'b0;
                d.oe     = 1'b0;
                d.dm     = '0;
            end
        end

        // Read capture on each returned strobe edge, pins not driven by us
        if (!q.oe && (q.dqs_sync[2] != q.dqs_sync[1])) begin
            if (!q.rd_beat) begin
                d.rd_lo   = q.dq_s2;
                d.rd_beat = 1'b1;
            end else begin
                d.rd_data  = {q.dq_s2, q.rd_lo};
                d.rd_valid = 1'b1;
                d.rd_beat  = 1'b0;
            end
        end
    end

    // Single state register; every local signal sits on clk_sys
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    // Error-correction register port and interrupt
    dlp_eccreg #(
        .AW (ECC_AW)
    ) u_ecc (
        .clk_sys             (clk_sys),
        .reset_n             (reset_n),
        .ecc_addr            (ecc_addr),
        .eccport_byte_enable (eccport_byte_enable),
        .ecc_wdata           (ecc_wdata),
        .ecc_read_req        (ecc_read_req),
        .ecc_write_req       (ecc_write_req),
        .ecc_rdata           (ecc_rdata),
        .ecc_err_single      (ecc_err_single),
        .ecc_err_double      (ecc_err_double),
        .ecc_interrupt       (ecc_interrupt)
    );

    // Outputs, all from the state register
    assign pwrdn_ack      = q.pd_ack;
    assign selfref_ack    = q.sr_ack;
    assign refresh_ack    = q.ref_ack;
    assign rd_data        = q.rd_data;
    assign rd_valid       = q.rd_valid;
    assign dram_cke       = q.cke;
    assign {dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n} = q.cmd;
    assign dram_dq_o      = q.dq_o;
    assign dram_dq_oe     = q.oe;
    assign dram_dqs_o     = {NB{q.dqs_o}};
    assign dram_dqs_oe    = q.oe;
    // Complement strobe is the true strobe inverted; its input is not needed
    assign dram_dqs_n_o   = ~{NB{q.dqs_o}};
    assign dram_dqs_n_oe  = q.oe;
    assign dram_byte_mask = q.dm;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    chk_pd_ack_cke: assert property ($rose(pwrdn_ack) |-> !dram_cke && $past(pwrdn_req))
        else $error("Power-down ack rose without clock enable low");
    chk_pd_hold: assert property (q.st == ST_PD && pwrdn_req && !q.ref_due |=> !dram_cke)
        else $error("Clock enable rose while power-down held");
    chk_pd_refresh: assert property (q.ref_due && q.st == ST_PD |-> ##[1:60] refresh_ack)
        else $error("Refresh not issued from power-down");
    chk_pd_ack_fall: assert property ($fell(pwrdn_ack) |-> dram_cke && $past(dram_cke, 2))
        else $error("Power-down ack fell before exit");
    chk_pd_disabled: assert property (!PD_EN |-> !pwrdn_ack)
        else $error("Power-down ack with option off");
    chk_sr_entry: assert property ($rose(selfref_ack) |-> !dram_cke && $past(selfref_req))
        else $error("Self-refresh ack without entry");
    chk_sr_hold: assert property (selfref_ack && selfref_req && q.st == ST_SR |=> !dram_cke)
        else $error("Self-refresh left while request held");
    chk_sr_ack_fall: assert property ($fell(selfref_ack) |-> dram_cke && $past(q.st) == ST_SR_EXIT)
        else $error("Self-refresh ack fell before exit");
    chk_sr_disabled: assert property (!SR_EN |-> !selfref_ack)
        else $error("Self-refresh ack with option off");
    chk_wr_strobe: assert property (dram_dq_oe |-> dram_dqs_oe && dram_dqs_n_oe && dram_dqs_n_o == ~dram_dqs_o)
        else $error("Write data without strobes");
    chk_wr_mask: assert property (buf_take |=> dram_byte_mask == ~$past(buf_data[2*DQ_W+NB-1:2*DQ_W]))
        else $error("Byte mask does not follow enables");
    chk_ref_pulse: assert property (refresh_ack
        |-> {dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n} == `DLP_CMD_REF ##1 !refresh_ack)
        else $error("Refresh ack longer than one cycle");
endmodule : dlp_ctrl

// ===== verification/dlp_mem_model.sv
`timescale 1ns/100ps
module dlp_mem_model (
    // Read frame trigger from the bench
    input  wire logic        rd_go,
    input  wire logic [15:0] rd_word,
    // Memory data pins toward the controller
    output logic [7:0]       dq,
    output logic [0:0]       dqs
);
    initial begin
        dq  = 8'h00;
        dqs = 1'b0;
    end
    // Strobe period 80 ns; data leads each edge by 20 ns, low half first
    always @(posedge rd_go) begin
        dq = rd_word[7:0];
        #20 dqs = 1'b1;
        #20 dq = rd_word[15:8];
        #20 dqs = 1'b0;
        // Hold time over: scramble the bus so stale data cannot pass
        #20 dq = ~rd_word[15:8];
    end
endmodule : dlp_mem_model

// ===== verification/testbench.sv
`timescale 1ns/100ps
`include "dlp_defs.svh"
module testbench;
    logic clk_sys, reset_n, pwrdn_req, selfref_req, wr_valid, rd_go, ecc_read_req, ecc_write_req;
    logic ecc_err_single, ecc_err_double;
    logic [15:0] wr_data, rd_word;
    logic [1:0] wr_be;
    logic [3:0] ecc_addr, eccport_byte_enable;
    logic [31:0] ecc_wdata;
    logic [0:0] dram_dqs_n_i;
    wire logic pwrdn_ack, selfref_ack, refresh_ack, wr_ready, rd_valid, dram_cke, dram_cs_n, dram_ras_n;
    wire logic dram_cas_n, dram_we_n, dram_dq_oe, dram_dqs_oe, dram_dqs_n_oe, ecc_interrupt;
    wire logic [15:0] rd_data;
    wire logic [7:0] dram_dq_i, dram_dq_o;
    wire logic [0:0] dram_dqs_i, dram_dqs_o, dram_dqs_n_o, dram_byte_mask;
    wire logic [31:0] ecc_rdata;
    int miscompares = 0, n_compared = 0, i, k, hi_cnt;
    logic [15:0] q_d[$];
    logic [1:0] q_b[$];

    dlp_ctrl DUT (.clk_sys, .reset_n, .pwrdn_req, .pwrdn_ack, .selfref_req, .selfref_ack, .refresh_ack,
        .wr_data, .wr_be, .wr_valid, .wr_ready, .rd_data, .rd_valid, .dram_cke, .dram_cs_n, .dram_ras_n,
        .dram_cas_n, .dram_we_n, .dram_dq_i, .dram_dq_o, .dram_dq_oe, .dram_dqs_i, .dram_dqs_o, .dram_dqs_oe,
        .dram_dqs_n_i, .dram_dqs_n_o, .dram_dqs_n_oe, .dram_byte_mask, .ecc_addr, .eccport_byte_enable,
        .ecc_wdata, .ecc_read_req, .ecc_write_req, .ecc_rdata, .ecc_err_single, .ecc_err_double, .ecc_interrupt);
    dlp_mem_model MEM (.rd_go(rd_go), .rd_word(rd_word), .dq(dram_dq_i), .dqs(dram_dqs_i));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One register access; read data is settled two falling edges later
    task automatic ecc(input logic [3:0] a, input logic w, input logic [31:0] d);
        ecc_addr = a;
        ecc_wdata = d;
        ecc_write_req = w;
        ecc_read_req = !w;
        @(negedge clk_sys);
        {ecc_write_req, ecc_read_req} = 2'h0;
        @(negedge clk_sys);
    endtask : ecc

    task automatic conclude();
        if (miscompares == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    // Cuts a hang short; the full run needs about 10 us
    initial begin
        #200000;
        miscompares++;
        conclude();
    end

    initial begin
        {reset_n, pwrdn_req, selfref_req, wr_valid, rd_go, ecc_read_req, ecc_write_req} = 7'h00;
        {ecc_err_single, ecc_err_double, wr_data, rd_word, wr_be, ecc_addr, ecc_wdata} = '0;
        eccport_byte_enable = 4'hf;
        dram_dqs_n_i = 1'b0;
        k = $urandom(6139);
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys) reset_n = 1'b1;
        @(negedge clk_sys);
        chk({pwrdn_ack, selfref_ack, dram_cke, wr_ready, ecc_interrupt}, 5'h06);
        // Power-down entry, then fill the buffer while the memory sleeps
        pwrdn_req = 1'b1;
        for (i = 0; i < 10 && !pwrdn_ack; i++) @(negedge clk_sys);
        chk({pwrdn_ack, dram_cke}, 2'h2);
        for (k = 0; k < 3; k++) begin
            wr_data = 16'($urandom);
            wr_be = 2'($urandom);
            wr_valid = wr_ready;
            if (wr_ready) begin
                q_d.push_back(wr_data);
                q_b.push_back(wr_be);
            end
            @(negedge clk_sys);
        end
        wr_valid = 1'b0;
        chk({wr_ready, 30'(q_d.size())}, 2);
        // Held past one refresh interval: exactly one refresh, ack never drops
        k = 0;
        for (i = 0; i < 900; i++) begin
            @(negedge clk_sys);
            chk(pwrdn_ack, 1);
            if (refresh_ack) begin
                k++;
                chk({dram_cs_n, dram_ras_n, dram_cas_n, dram_we_n}, `DLP_CMD_REF);
            end
        end
        chk({k[30:0], dram_dq_oe}, 2);
        pwrdn_req = 1'b0;
        hi_cnt = 0;
        for (i = 0; i < 40 && pwrdn_ack; i++) begin
            @(negedge clk_sys);
            hi_cnt = dram_cke ? hi_cnt + 1 : 0;
        end
        chk({pwrdn_ack, hi_cnt >= 4}, 1);
        // Buffered words leave low half first with strobe and byte mask
        while (q_d.size() > 0) begin
            for (i = 0; i < 40 && !(dram_dq_oe && dram_dqs_o[0]); i++) @(negedge clk_sys);
            chk({dram_dq_o, dram_byte_mask, dram_dqs_n_o}, {q_d[0][7:0], ~q_b[0][0], 1'b0});
            repeat (4) @(negedge clk_sys);
            chk({dram_dq_o, dram_byte_mask, dram_dqs_o}, {q_d[0][15:8], ~q_b[0][1], 1'b0});
            void'(q_d.pop_front());
            void'(q_b.pop_front());
        end
        repeat (5) @(negedge clk_sys);
        chk({dram_dq_oe, dram_byte_mask}, 0);
        // Self-refresh: enter, hold, leave only after the exit time
        selfref_req = 1'b1;
        for (i = 0; i < 30 && !selfref_ack; i++) @(negedge clk_sys);
        chk({selfref_ack, dram_cke}, 2'h2);
        repeat (20) @(negedge clk_sys);
        chk({selfref_ack, dram_cke}, 2'h2);
        selfref_req = 1'b0;
        hi_cnt = 0;
        for (i = 0; i < 60 && selfref_ack; i++) begin
            @(negedge clk_sys);
            hi_cnt = dram_cke ? hi_cnt + 1 : 0;
        end
        chk({selfref_ack, hi_cnt >= 17}, 1);
        // Read frames from the memory model
        for (k = 0; k < 2; k++) begin
            rd_word = 16'($urandom);
            rd_go = 1'b1;
            @(negedge clk_sys) rd_go = 1'b0;
            for (i = 0; i < 40 && !rd_valid; i++) @(negedge clk_sys);
            chk(rd_data, rd_word);
        end
        // Error events, mask, clear and an unmapped read
        ecc_err_single = 1'b1;
        @(negedge clk_sys) ecc_err_single = 1'b0;
        @(negedge clk_sys);
        chk(ecc_interrupt, 1);
        ecc(4'h0, 1'b0, 0);
        chk(ecc_rdata, 1);
        ecc(4'h2, 1'b0, 0);
        chk(ecc_rdata, 1);
        ecc(4'h1, 1'b1, 1);
        chk(ecc_interrupt, 0);
        ecc(4'h1, 1'b1, 0);
        chk(ecc_interrupt, 1);
        ecc_err_double = 1'b1;
        @(negedge clk_sys) ecc_err_double = 1'b0;
        ecc(4'h0, 1'b0, 0);
        chk(ecc_rdata, 3);
        eccport_byte_enable = 4'he;
        ecc(4'h0, 1'b1, 3);
        chk(ecc_interrupt, 1);
        eccport_byte_enable = 4'hf;
        ecc(4'h0, 1'b1, 3);
        chk(ecc_interrupt, 0);
        ecc(4'h7, 1'b0, 0);
        chk(ecc_rdata, 0);
        conclude();
    end
endmodule : testbench
